// ===== hdl/ipcfg_device.sv
// Interrupt priority controller: device end of the priority link.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ipcfg_params.svh"

// Overview of operation
// - Three-bit field, seven is highest level
// - Field zero disables the source entirely
// - Reset sets every field to four
// - Unimplemented bits ignore writes, read zero
// - Bit fifteen set blocks interrupt nesting
// - Software clears flag before enabling source
// - Only enabled sources may request service
// - Flag stays set until software clears
// - Return restores previous processor priority unless an ack comes in the same cycle
// - Trap flags stay set until cleared
// - Register two: receive, event, fault, timer
// - Register three: converter and transmit only
// - Software may give all one level
module ipcfg_device
    import ipcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ipcfg_link_if.dev link,
    input wire logic [`IPCFG_NUM_SRC-1:0] srcEvent,
    input wire logic [`IPCFG_NUM_TRAP-1:0] trapEvent,
    output logic [2:0] cpuPriority
);

    // ============================================================
    // Field placement
    // Sources 0..3 sit in register 0, 4..7 in register 2 and
    // 8..9 in register 3, each at slot (index mod 4).
    function automatic logic [2:0] fieldAddr(input int idx);
        if (idx < `IPCFG_SRC_PER_REG) begin
            return `IPCFG_ADDR_PRI0;
        end else if (idx < 2 * `IPCFG_SRC_PER_REG) begin
            return `IPCFG_ADDR_PRI2;
        end else begin
            return `IPCFG_ADDR_PRI3;
        end
    endfunction

    // ============================================================
    // State
    ipcfg_prio_type [`IPCFG_NUM_SRC-1:0] prio_reg;
    ipcfg_prio_type [`IPCFG_NUM_SRC-1:0] prio_next;
    logic [`IPCFG_NUM_SRC-1:0] flag_reg;
    logic [`IPCFG_NUM_SRC-1:0] flag_next;
    logic [`IPCFG_NUM_SRC-1:0] enable_reg;
    logic [`IPCFG_NUM_SRC-1:0] enable_next;
    logic nestDis_reg;
    logic nestDis_next;
    logic [`IPCFG_NUM_TRAP-1:0] trapFlag_reg;
    logic [`IPCFG_NUM_TRAP-1:0] trapFlag_next;
    ipcfg_prio_type stack_reg [`IPCFG_STACK_DEPTH];
    ipcfg_prio_type stack_next [`IPCFG_STACK_DEPTH];
    logic [3:0] depth_reg;
    logic [3:0] depth_next;
    ipcfg_prio_type cpuLevel_reg;
    ipcfg_prio_type cpuLevel_next;
    logic irqReq_reg;
    logic irqReq_next;
    ipcfg_prio_type irqLevel_reg;
    ipcfg_prio_type irqLevel_next;
    ipcfg_src_type irqSource_reg;
    ipcfg_src_type irqSource_next;
    logic trapReq_reg;
    logic trapReq_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    logic bestValid;
    ipcfg_prio_type bestLevel;
    ipcfg_src_type bestSource;

    ipcfg_pick u_pick (
        .flags(flag_reg),
        .enables(enable_reg),
        .levels(prio_reg),
        .bestValid(bestValid),
        .bestLevel(bestLevel),
        .bestSource(bestSource)
    );

    // ============================================================
    // Next state
    always_comb begin
        logic wrCtl;
        logic wrFlag;
        logic wrEnable;
        logic ackNow;
        logic retNow;
        logic reqOk;
        logic [2:0] topIdx;
        wrCtl = link.cfgWrite && (link.cfgAddr == `IPCFG_ADDR_INTCTL);
        wrFlag = link.cfgWrite && (link.cfgAddr == `IPCFG_ADDR_FLAG);
        wrEnable = link.cfgWrite && (link.cfgAddr == `IPCFG_ADDR_ENABLE);
        ackNow = link.irqAck && irqReq_reg;
        retNow = link.intReturn && (depth_reg != 4'h0);
        topIdx = 3'(depth_reg - 4'h1);

        prio_next = prio_reg;
        // Only the three field bits of each slot are stored, so the
        // spare bits of a written word simply vanish.
        for (int i = 0; i < `IPCFG_NUM_SRC; i++) begin
            if (link.cfgWrite && (link.cfgAddr == fieldAddr(i))) begin
                prio_next[i] =
                    link.cfgWdata[4 * (i % `IPCFG_SRC_PER_REG) +: 3];
            end
        end

        // A peripheral event in the same cycle as a clear wins.
        flag_next = (wrFlag ? link.cfgWdata[`IPCFG_NUM_SRC-1:0] : flag_reg)
            | srcEvent;
        enable_next = wrEnable ? link.cfgWdata[`IPCFG_NUM_SRC-1:0]
            : enable_reg;
        nestDis_next = wrCtl ? link.cfgWdata[`IPCFG_NEST_DIS_BIT]
            : nestDis_reg;
        // Software can only clear a trap flag, never raise one.
        trapFlag_next = (wrCtl ? (trapFlag_reg &
            link.cfgWdata[`IPCFG_TRAP_MSB:`IPCFG_TRAP_LSB]) : trapFlag_reg)
            | trapEvent;
        trapReq_next = |trapFlag_next;

        stack_next = stack_reg;
        depth_next = depth_reg;
        cpuLevel_next = cpuLevel_reg;
        if (ackNow) begin
            stack_next[depth_reg[2:0]] = cpuLevel_reg;
            depth_next = depth_reg + 4'h1;
            cpuLevel_next = irqLevel_reg;
        end else if (retNow) begin
            depth_next = depth_reg - 4'h1;
            cpuLevel_next = stack_reg[topIdx];
        end

        // With nesting off nothing is offered while a routine runs.
        reqOk = bestValid && (bestLevel > cpuLevel_reg) &&
            !(nestDis_reg && (depth_reg != 4'h0));
        // The accepted request drops at once so the core end never
        // takes the same vector twice.
        irqReq_next = reqOk && !ackNow;
        irqLevel_next = irqLevel_reg;
        irqSource_next = irqSource_reg;
        if (reqOk) begin
            irqLevel_next = bestLevel;
            irqSource_next = bestSource;
        end

        rvalid_next = link.cfgRead;
        rdata_next = rdata_reg;
        if (link.cfgRead) begin
            rdata_next = 16'h0000;
            unique case (link.cfgAddr)
                `IPCFG_ADDR_INTCTL: begin
                    rdata_next[`IPCFG_NEST_DIS_BIT] = nestDis_reg;
                    rdata_next[`IPCFG_LEVEL_LSB +: 3] = cpuLevel_reg;
                    rdata_next[`IPCFG_TRAP_MSB:`IPCFG_TRAP_LSB] =
                        trapFlag_reg;
                end
                `IPCFG_ADDR_FLAG: begin
                    rdata_next[`IPCFG_NUM_SRC-1:0] = flag_reg;
                end
                `IPCFG_ADDR_ENABLE: begin
                    rdata_next[`IPCFG_NUM_SRC-1:0] = enable_reg;
                end
                default: begin
                    for (int i = 0; i < `IPCFG_NUM_SRC; i++) begin
                        if (link.cfgAddr == fieldAddr(i)) begin
                            rdata_next[4 * (i % `IPCFG_SRC_PER_REG) +: 3] =
                                prio_reg[i];
                        end
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `IPCFG_NUM_SRC; i++) begin
                prio_reg[i] <= `IPCFG_PRIO_RESET;
            end
            flag_reg <= '0;
            enable_reg <= '0;
            nestDis_reg <= 1'b0;
            trapFlag_reg <= '0;
            for (int i = 0; i < `IPCFG_STACK_DEPTH; i++) begin
                stack_reg[i] <= `IPCFG_PRIO_OFF;
            end
            depth_reg <= 4'h0;
            cpuLevel_reg <= `IPCFG_PRIO_OFF;
            irqReq_reg <= 1'b0;
            irqLevel_reg <= `IPCFG_PRIO_OFF;
            irqSource_reg <= 4'h0;
            trapReq_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            prio_reg <= prio_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
            nestDis_reg <= nestDis_next;
            trapFlag_reg <= trapFlag_next;
            stack_reg <= stack_next;
            depth_reg <= depth_next;
            cpuLevel_reg <= cpuLevel_next;
            irqReq_reg <= irqReq_next;
            irqLevel_reg <= irqLevel_next;
            irqSource_reg <= irqSource_next;
            trapReq_reg <= trapReq_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ============================================================
    // Outputs
    assign link.irqReq = irqReq_reg;
    assign link.irqLevel = irqLevel_reg;
    assign link.irqSource = irqSource_reg;
    assign link.trapReq = trapReq_reg;
    assign link.cfgRdata = rdata_reg;
    assign link.cfgRvalid = rvalid_reg;
    assign cpuPriority = cpuLevel_reg;

endmodule

`default_nettype wire

// ===== common/ipcfg_params.svh
// Offsets, field positions, reset values and sizes of the priority link.
`ifndef IPCFG_PARAMS_SVH
`define IPCFG_PARAMS_SVH

// ============================================================
// Device register select codes
`define IPCFG_ADDR_INTCTL 3'h0
`define IPCFG_ADDR_FLAG 3'h1
`define IPCFG_ADDR_ENABLE 3'h2
`define IPCFG_ADDR_PRI0 3'h4
`define IPCFG_ADDR_PRI2 3'h6
`define IPCFG_ADDR_PRI3 3'h7

// ============================================================
// Device field positions and reset values
`define IPCFG_NEST_DIS_BIT 15
`define IPCFG_LEVEL_LSB 8
`define IPCFG_TRAP_LSB 1
`define IPCFG_TRAP_MSB 4
`define IPCFG_PRIO_RESET 3'h4
`define IPCFG_PRIO_OFF 3'h0
`define IPCFG_NUM_SRC 10
`define IPCFG_NUM_TRAP 4
`define IPCFG_STACK_DEPTH 8
`define IPCFG_SRC_PER_REG 4

// ============================================================
// Core end register map, word addresses
`define IPCFG_HOST_CMD 3'h0
`define IPCFG_HOST_RESULT 3'h1
`define IPCFG_HOST_VECTOR 3'h2
`define IPCFG_HOST_CTRL 3'h3
`define IPCFG_HOST_EV_STATUS 3'h4
`define IPCFG_HOST_EV_CLEAR 3'h5
`define IPCFG_HOST_EV_ENABLE 3'h6

// ============================================================
// Core end fields
`define IPCFG_CMD_ADDR_LSB 16
`define IPCFG_CMD_READ_BIT 20
`define IPCFG_CTRL_AUTO_BIT 0
`define IPCFG_CTRL_RET_BIT 1
`define IPCFG_EV_TAKEN 0
`define IPCFG_EV_RDDONE 1
`define IPCFG_EV_TRAP 2
`define IPCFG_NUM_EV 3

`endif

// ===== common/ipcfg_pkg.sv
// Types shared by both ends of the priority link.
`default_nettype none

package ipcfg_pkg;

    typedef logic [2:0] ipcfg_prio_type;
    typedef logic [3:0] ipcfg_src_type;

    typedef enum logic [2:0] {
        LS_IDLE = 3'h1,
        LS_ISSUE = 3'h2,
        LS_WAIT = 3'h4
    } ipcfg_link_state_type;

endpackage

`default_nettype wire

// ===== common/ipcfg_link_if.sv
// Link between the priority controller and the processor core end.
`timescale 1ns/10ps
`default_nettype none

interface ipcfg_link_if
    import ipcfg_pkg::*;
();
    logic cfgWrite;
    logic cfgRead;
    logic [2:0] cfgAddr;
    logic [15:0] cfgWdata;
    logic [15:0] cfgRdata;
    logic cfgRvalid;
    logic irqReq;
    ipcfg_prio_type irqLevel;
    ipcfg_src_type irqSource;
    logic trapReq;
    logic irqAck;
    logic intReturn;

    modport dev (
        input cfgWrite, cfgRead, cfgAddr, cfgWdata, irqAck, intReturn,
        output cfgRdata, cfgRvalid, irqReq, irqLevel, irqSource, trapReq
    );

    modport core (
        output cfgWrite, cfgRead, cfgAddr, cfgWdata, irqAck, intReturn,
        input cfgRdata, cfgRvalid, irqReq, irqLevel, irqSource, trapReq
    );
endinterface

`default_nettype wire

// ===== hdl/ipcfg_pick.sv
// Selects the pending, enabled source of highest priority.
`timescale 1ns/10ps
`default_nettype none
`include "ipcfg_params.svh"

module ipcfg_pick
    import ipcfg_pkg::*;
(
    input wire logic [`IPCFG_NUM_SRC-1:0] flags,
    input wire logic [`IPCFG_NUM_SRC-1:0] enables,
    input wire ipcfg_prio_type [`IPCFG_NUM_SRC-1:0] levels,
    output logic bestValid,
    output ipcfg_prio_type bestLevel,
    output ipcfg_src_type bestSource
);

    logic [`IPCFG_NUM_SRC-1:0] eligible;

    genvar g;
    generate
        for (g = 0; g < `IPCFG_NUM_SRC; g++) begin : gen_elig
            // A zero field silences the source whatever its flag says.
            assign eligible[g] = flags[g] && enables[g] &&
                (levels[g] != `IPCFG_PRIO_OFF);
        end
    endgenerate

    // Strict comparison lets the lowest index win a tie.
    always_comb begin
        bestValid = 1'b0;
        bestLevel = `IPCFG_PRIO_OFF;
        bestSource = 4'h0;
        for (int i = 0; i < `IPCFG_NUM_SRC; i++) begin
            if (eligible[i] && (levels[i] > bestLevel)) begin
                bestValid = 1'b1;
                bestLevel = levels[i];
                bestSource = ipcfg_src_type'(i);
            end
        end
    end

endmodule

`default_nettype wire

// ===== hdl/ipcfg_core_end.sv
// Processor core end: takes vectors and runs register commands.
`timescale 1ns/10ps
`default_nettype none
`include "ipcfg_params.svh"

module ipcfg_core_end
    import ipcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ipcfg_link_if.core link,
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq
);

    ipcfg_link_state_type state_reg;
    ipcfg_link_state_type state_next;
    logic waitReq_reg;
    logic waitReq_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic autoAck_reg;
    logic autoAck_next;
    logic [`IPCFG_NUM_EV-1:0] evStatus_reg;
    logic [`IPCFG_NUM_EV-1:0] evStatus_next;
    logic [`IPCFG_NUM_EV-1:0] evEnable_reg;
    logic [`IPCFG_NUM_EV-1:0] evEnable_next;
    logic irq_reg;
    logic irq_next;
    logic [15:0] result_reg;
    logic [15:0] result_next;
    ipcfg_prio_type vecLevel_reg;
    ipcfg_prio_type vecLevel_next;
    ipcfg_src_type vecSource_reg;
    ipcfg_src_type vecSource_next;
    logic [2:0] cfgAddr_reg;
    logic [2:0] cfgAddr_next;
    logic [15:0] cfgWdata_reg;
    logic [15:0] cfgWdata_next;
    logic cfgWrite_reg;
    logic cfgWrite_next;
    logic cfgRead_reg;
    logic cfgRead_next;
    logic irqAck_reg;
    logic irqAck_next;
    logic intReturn_reg;
    logic intReturn_next;
    logic trapPrev_reg;
    logic trapPrev_next;

    // ============================================================
    // Next state
    always_comb begin
        logic wrAcc;
        logic [`IPCFG_NUM_EV-1:0] events;
        logic [`IPCFG_NUM_EV-1:0] clears;
        wrAcc = write && !waitReq_reg;
        // One wait cycle per access; the slave never stalls longer.
        waitReq_next = !((read || write) && waitReq_reg);
        events = '0;
        clears = '0;

        readdata_next = readdata_reg;
        if (read && waitReq_reg) begin
            readdata_next = 32'h00000000;
            unique case (address)
                `IPCFG_HOST_CMD: readdata_next[0] = (state_reg != LS_IDLE);
                `IPCFG_HOST_RESULT: readdata_next[15:0] = result_reg;
                `IPCFG_HOST_VECTOR: readdata_next[6:0] =
                    {vecLevel_reg, vecSource_reg};
                `IPCFG_HOST_CTRL: readdata_next[`IPCFG_CTRL_AUTO_BIT] =
                    autoAck_reg;
                `IPCFG_HOST_EV_STATUS: readdata_next[`IPCFG_NUM_EV-1:0] =
                    evStatus_reg;
                `IPCFG_HOST_EV_ENABLE: readdata_next[`IPCFG_NUM_EV-1:0] =
                    evEnable_reg;
                default: readdata_next = 32'h00000000;
            endcase
        end

        autoAck_next = autoAck_reg;
        evEnable_next = evEnable_reg;
        intReturn_next = 1'b0;
        if (wrAcc && (address == `IPCFG_HOST_CTRL)) begin
            autoAck_next = writedata[`IPCFG_CTRL_AUTO_BIT];
            intReturn_next = writedata[`IPCFG_CTRL_RET_BIT];
        end
        if (wrAcc && (address == `IPCFG_HOST_EV_ENABLE)) begin
            evEnable_next = writedata[`IPCFG_NUM_EV-1:0];
        end
        if (wrAcc && (address == `IPCFG_HOST_EV_CLEAR)) begin
            clears = writedata[`IPCFG_NUM_EV-1:0];
        end

        // The device drops its request one edge after the ack, so a
        // second ack is held off for that edge.
        irqAck_next = autoAck_reg && link.irqReq && !irqAck_reg;
        vecLevel_next = vecLevel_reg;
        vecSource_next = vecSource_reg;
        if (irqAck_next) begin
            vecLevel_next = link.irqLevel;
            vecSource_next = link.irqSource;
            events[`IPCFG_EV_TAKEN] = 1'b1;
        end
        trapPrev_next = link.trapReq;
        events[`IPCFG_EV_TRAP] = link.trapReq && !trapPrev_reg;

        state_next = state_reg;
        cfgAddr_next = cfgAddr_reg;
        cfgWdata_next = cfgWdata_reg;
        cfgWrite_next = 1'b0;
        cfgRead_next = 1'b0;
        result_next = result_reg;
        unique case (state_reg)
            LS_IDLE: begin
                // Flag clears and enables are issued as software
                // orders them; this end keeps that order.
                if (wrAcc && (address == `IPCFG_HOST_CMD)) begin
                    cfgAddr_next = writedata[`IPCFG_CMD_ADDR_LSB +: 3];
                    cfgWdata_next = writedata[15:0];
                    cfgRead_next = writedata[`IPCFG_CMD_READ_BIT];
                    cfgWrite_next = !writedata[`IPCFG_CMD_READ_BIT];
                    state_next = LS_ISSUE;
                end
            end
            LS_ISSUE: begin
                state_next = cfgRead_reg ? LS_WAIT : LS_IDLE;
            end
            LS_WAIT: begin
                if (link.cfgRvalid) begin
                    result_next = link.cfgRdata;
                    events[`IPCFG_EV_RDDONE] = 1'b1;
                    state_next = LS_IDLE;
                end
            end
        endcase

        // A new event outranks a clear arriving in the same cycle.
        evStatus_next = (evStatus_reg & ~clears) | events;
        irq_next = |(evStatus_next & evEnable_next);
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= LS_IDLE;
            waitReq_reg <= 1'b1;
            readdata_reg <= 32'h00000000;
            autoAck_reg <= 1'b0;
            evStatus_reg <= '0;
            evEnable_reg <= '0;
            irq_reg <= 1'b0;
            result_reg <= 16'h0000;
            vecLevel_reg <= 3'h0;
            vecSource_reg <= 4'h0;
            cfgAddr_reg <= 3'h0;
            cfgWdata_reg <= 16'h0000;
            cfgWrite_reg <= 1'b0;
            cfgRead_reg <= 1'b0;
            irqAck_reg <= 1'b0;
            intReturn_reg <= 1'b0;
            trapPrev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            waitReq_reg <= waitReq_next;
            readdata_reg <= readdata_next;
            autoAck_reg <= autoAck_next;
            evStatus_reg <= evStatus_next;
            evEnable_reg <= evEnable_next;
            irq_reg <= irq_next;
            result_reg <= result_next;
            vecLevel_reg <= vecLevel_next;
            vecSource_reg <= vecSource_next;
            cfgAddr_reg <= cfgAddr_next;
            cfgWdata_reg <= cfgWdata_next;
            cfgWrite_reg <= cfgWrite_next;
            cfgRead_reg <= cfgRead_next;
            irqAck_reg <= irqAck_next;
            intReturn_reg <= intReturn_next;
            trapPrev_reg <= trapPrev_next;
        end
    end

    assign link.cfgAddr = cfgAddr_reg;
    assign link.cfgWdata = cfgWdata_reg;
    assign link.cfgWrite = cfgWrite_reg;
    assign link.cfgRead = cfgRead_reg;
    assign link.irqAck = irqAck_reg;
    assign link.intReturn = intReturn_reg;
    assign readdata = readdata_reg;
    assign waitrequest = waitReq_reg;
    assign irq = irq_reg;

endmodule

`default_nettype wire

// ===== dv/ipcfg_link_checker.sv
// Concurrent checks on the link between the two ends.
`timescale 1ns/10ps
`default_nettype none
`include "ipcfg_params.svh"

module ipcfg_link_checker
    import ipcfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [2:0] cfgAddr,
    input wire logic [15:0] cfgRdata,
    input wire logic cfgRvalid,
    input wire logic irqReq,
    input wire ipcfg_prio_type irqLevel,
    input wire logic trapReq,
    input wire logic irqAck
);
    // ============================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    read_answer_a: assert property (cfgRead |=> cfgRvalid)
        else $error("Read answer missing");
    answer_cause_a: assert property (cfgRvalid |-> $past(cfgRead))
        else $error("Read answer without a read");
    level_nonzero_a: assert property (irqReq |-> irqLevel != 3'h0)
        else $error("Request at disabled level");
    ack_drop_a: assert property (irqReq && irqAck |=> !irqReq)
        else $error("Request kept after acknowledge");
    ack_pending_a: assert property (irqAck |-> irqReq)
        else $error("Acknowledge without request");
    pri3_top_a: assert property (
        cfgRead && cfgAddr == `IPCFG_ADDR_PRI3 |=> cfgRdata[15:7] == 9'h000)
        else $error("Upper bits not zero");
    pri_gaps_a: assert property (
        cfgRead && (cfgAddr == `IPCFG_ADDR_PRI0 ||
        cfgAddr == `IPCFG_ADDR_PRI2) |=> (cfgRdata & 16'h8888) == 16'h0000)
        else $error("Gap bits not zero");
    unused_regs_a: assert property (cfgRead && cfgAddr[1:0] == 2'h3
        && cfgAddr != 3'h7 |=> cfgRdata == 16'h0000) else $error("Hole not 0");
    trap_hold_a: assert property (trapReq && !cfgWrite
        && !$past(cfgWrite) |=> trapReq) else $error("Trap flag lost");

    // ============================================================
    // Coverage
    cover property (irqReq && irqAck);
    cover property ($rose(trapReq));
    cover property (cfgRead && cfgAddr == `IPCFG_ADDR_PRI3);
endmodule

`default_nettype wire

// ===== dv/ipcfg_tb.sv
// Self-checking bench for the priority controller and its core end.
`timescale 1ns/10ps
`default_nettype none
`include "ipcfg_params.svh"

module tb
    import ipcfg_pkg::*;
;
    typedef struct {logic [2:0] a; logic [15:0] rv; logic [15:0] wv;}
        ipcfg_row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] address = 3'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic [9:0] srcEvent = 10'h0;
    logic [3:0] trapEvent = 4'h0;
    logic [2:0] cpuPriority;
    logic [31:0] q;
    int fails = 0;
    int testsRun = 0;
    ipcfg_row_type rows [5] = '{'{3'h4, 16'h4444, 16'h7777},
        '{3'h6, 16'h4444, 16'h7777}, '{3'h7, 16'h0044, 16'h0077},
        '{3'h3, 16'h0000, 16'h0000}, '{3'h5, 16'h0000, 16'h0000}};

    always #4 clk = ~clk;

    ipcfg_link_if link ();
    ipcfg_device u_ipcfg_device (.clk(clk), .rst(rst), .link(link.dev),
        .srcEvent(srcEvent), .trapEvent(trapEvent),
        .cpuPriority(cpuPriority));
    ipcfg_core_end u_ipcfg_core_end (.clk(clk), .rst(rst), .link(link.core),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq));
    ipcfg_link_checker u_checker (.clk(clk), .rst(rst),
        .cfgWrite(link.cfgWrite), .cfgRead(link.cfgRead),
        .cfgAddr(link.cfgAddr), .cfgRdata(link.cfgRdata),
        .cfgRvalid(link.cfgRvalid), .irqReq(link.irqReq),
        .irqLevel(link.irqLevel), .trapReq(link.trapReq),
        .irqAck(link.irqAck));

    // ============================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // The request is held until the edge that samples waitrequest low.
    task automatic av(input logic wr, input logic [2:0] a,
        input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic dev(input logic rd, input logic [2:0] a,
        input logic [15:0] d);
        av(1'b1, 3'h0, {11'h0, rd, 1'b0, a, d});
        do av(1'b0, 3'h0, 32'h0); while (q[0] !== 1'b0);
        if (rd) av(1'b0, 3'h1, 32'h0);
    endtask

    task automatic pulse(input logic [9:0] s, input logic [3:0] t);
        @(posedge clk);
        srcEvent <= s;
        trapEvent <= t;
        @(posedge clk);
        srcEvent <= 10'h0;
        trapEvent <= 4'h0;
    endtask

    task automatic wait_pri(input logic [2:0] exp);
        repeat (20) begin
            @(posedge clk);
            if (cpuPriority === exp) break;
        end
        chk({13'h0, cpuPriority}, {13'h0, exp});
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            dev(1'b1, rows[i].a, 16'h0);
            chk(q[15:0], rows[i].rv);
            dev(1'b0, rows[i].a, 16'hffff);
            dev(1'b1, rows[i].a, 16'h0);
            chk(q[15:0], rows[i].wv);
        end
        av(1'b1, 3'h6, 32'h1);
        av(1'b1, 3'h3, 32'h1);
        dev(1'b0, 3'h4, 16'h1234);
        dev(1'b0, 3'h1, 16'h0);
        pulse(10'h00f, 4'h0);
        repeat (4) @(posedge clk);
        chk({15'h0, link.irqReq}, 16'h0);
        dev(1'b0, 3'h2, 16'h03ff);
        wait_pri(3'h4);
        av(1'b0, 3'h2, 32'h0);
        chk(q[15:0], 16'h0040);
        chk({15'h0, irq}, 16'h1);
        av(1'b1, 3'h6, 32'h0);
        repeat (2) @(posedge clk);
        chk({15'h0, irq}, 16'h0);
        av(1'b1, 3'h6, 32'h1);
        av(1'b1, 3'h5, 32'h7);
        repeat (2) @(posedge clk);
        chk({15'h0, irq}, 16'h0);
        av(1'b0, 3'h7, 32'h0);
        chk(q[15:0], 16'h0);
        dev(1'b1, 3'h1, 16'h0);
        chk(q[15:0], 16'h000f);
        chk({15'h0, link.irqReq}, 16'h0);
        dev(1'b0, 3'h1, 16'h000e);
        dev(1'b0, 3'h4, 16'h0000);
        av(1'b1, 3'h3, 32'h3);
        wait_pri(3'h0);
        repeat (4) @(posedge clk);
        chk({15'h0, link.irqReq}, 16'h0);
        dev(1'b0, 3'h4, 16'h0030);
        wait_pri(3'h3);
        av(1'b0, 3'h2, 32'h0);
        chk(q[15:0], 16'h0031);
        dev(1'b0, 3'h0, 16'h8000);
        pulse(10'h010, 4'h0);
        repeat (10) @(posedge clk);
        chk({13'h0, cpuPriority}, 16'h3);
        dev(1'b0, 3'h0, 16'h0000);
        wait_pri(3'h7);
        pulse(10'h000, 4'h2);
        repeat (4) @(posedge clk);
        dev(1'b1, 3'h0, 16'h0);
        chk(q[15:0], 16'h0704);
        dev(1'b0, 3'h0, 16'h0000);
        dev(1'b1, 3'h0, 16'h0);
        chk(q[15:0], 16'h0700);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        dev(1'b1, 3'h4, 16'h0);
        chk(q[15:0], 16'h4444);
        chk({13'h0, cpuPriority}, 16'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
